// File: core/estc_prescaler.v
// Prescaler: 15-bit ripple-free divider producing a tick per selected ratio.
// Assumes i_tick is a one-cycle pulse per source rising edge on i_clk.
`timescale 1ns/1ps
`include "estc_timer_map.vh"

module estc_prescaler #(
  parameter WIDTH = `ESTC_PRESCALE_WIDTH
) (
  input  wire       i_clk,
  input  wire       i_sys_rst,
  input  wire       i_clear,
  input  wire       i_tick,
  input  wire [3:0] i_select,
  output wire       o_tick
);

  reg  [WIDTH-1:0] count;
  wire [WIDTH:0]   ext_count;
  wire             terminal;

  // ================================================================
  // Division counter
  always @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      count <= {WIDTH{1'b0}};
    else if (i_clear)
      count <= {WIDTH{1'b0}};
    else if (i_tick)
    begin
      if (terminal)
        count <= {WIDTH{1'b0}};
      else
        count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // Ratio 2^sel: terminal when the low sel bits are all ones
  assign ext_count = {1'b1, count};
  assign terminal  = &(ext_count | ~(({{WIDTH{1'b0}}, 1'b1} << i_select)
                       - {{WIDTH{1'b0}}, 1'b1}));
  assign o_tick    = i_tick & terminal;

endmodule // estc_prescaler

// File: core/estc_timer.v
// Timer/counter top: source select, sync, prescaler, 8/16-bit count, postscaler.
// Assumes software strobes are one-cycle pulses synchronous to i_clk.
`timescale 1ns/1ps
`include "estc_timer_map.vh"

// Overview of operation
// - One control bit chooses 8-bit or 16-bit counting.
// - Instruction-clock source counts once per instruction cycle as a timer.
// - Other sources count on each rising edge of that source.
// - A 15-bit prescaler sits between clock input and counter.
// - In 16-bit mode reading low byte copies true high byte to buffer.
// - In 16-bit mode writing low byte loads true high byte from buffer.
// - In 8-bit mode high register is period, compared every count clock.
// - Period match clears low count, copies period to buffer; postscaled match pulses output.
// - In 8-bit mode low and period registers are plain read/write.
// - Reset clears low count and sets high/period register to all ones.
// - Low write, control writes and reset clear prescaler and postscaler.
// - Counter mode undivided: each input edge adds one, synchronised edges at most one per instruction cycle.
// - Timer mode undivided advances each instruction cycle, else prescaled rate.
// - Unsynchronised input counts each rising edge, continuing while asleep.
// - Synchronised input is aligned to the instruction clock before counting.
// - Three-bit field selects the counter clock source.
// - Event flag raised on 8-bit match or 16-bit overflow.
// - Four-bit prescale field picks powers of two up to 1:32768.
// - Postscale field N sets flag every N+1 matches or overflows.
// - 16-bit overflow occurs rolling from all ones to zero.
// - Enable bit runs the module; clear means disabled, lowest power.
module estc_timer #(
  parameter PRESCALE_WIDTH = `ESTC_PRESCALE_WIDTH
) (
  input  wire       i_clk,
  input  wire       i_sys_rst,
  input  wire       i_sleep,
  input  wire       i_pin_clk,
  input  wire       i_hfosc_clk,
  input  wire       i_lfosc_clk,
  input  wire       i_sosc_clk,
  input  wire       i_logic_clk,
  input  wire [7:0] i_wdata,
  input  wire       i_low_write,
  input  wire       i_high_write,
  input  wire       i_low_read,
  input  wire       i_ctla_write,
  input  wire       i_ctlb_write,
  input  wire       i_flag_clear,
  output reg  [7:0] o_count_low_byte,
  output reg  [7:0] o_high_buffer_or_period,
  output reg  [7:0] o_timer_control_a,
  output reg  [7:0] o_timer_control_b,
  output reg        o_timer_output_pulse,
  output reg        o_timer_output_level,
  output reg        o_match_event_flag
);

  localparam integer INSTR_DIV  = `ESTC_INSTR_DIV;
  localparam [1:0]   INSTR_LAST = INSTR_DIV[1:0] - 2'h1;

  reg  [1:0] instr_phase;
  reg  [7:0] true_high;
  reg  [7:0] period_buffer;
  reg  [3:0] post_count;
  reg        src_level;
  reg        edge_prev;
  reg        sync_hold;
  reg        next_src_level;
  reg        src_tick;
  wire       instr_tick;
  wire       raw_rise;
  wire       sync_rise;
  wire       ctr_tick;
  wire       enable;
  wire       wide;
  wire       unsync;
  wire [2:0] src_sel;
  wire       presc_clear;
  wire       match8;
  wire       roll16;
  wire       event_hit;
  wire       post_done;

  assign enable  = o_timer_control_a[7];
  assign wide    = o_timer_control_a[4];
  assign src_sel = o_timer_control_b[`ESTC_CTLB_CS_MSB:`ESTC_CTLB_CS_LSB];
  assign unsync  = o_timer_control_b[`ESTC_CTLB_ASYNC_BIT];

  // ================================================================
  // Instruction clock phase (system clock divided by four)
  always @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      instr_phase <= 2'h0;
    else
      instr_phase <= instr_phase + 2'h1;
  end
  assign instr_tick = (instr_phase == INSTR_LAST);

  // ================================================================
  // Source select
  always @*
  begin
    next_src_level = 1'b0;
    case (src_sel)
      `ESTC_CS_PIN_TRUE: next_src_level = i_pin_clk;
      `ESTC_CS_PIN_INV:  next_src_level = ~i_pin_clk;
      `ESTC_CS_HFOSC:    next_src_level = i_hfosc_clk;
      `ESTC_CS_LFOSC:    next_src_level = i_lfosc_clk;
      `ESTC_CS_SOSC:     next_src_level = i_sosc_clk;
      `ESTC_CS_LOGIC:    next_src_level = i_logic_clk;
      default:           next_src_level = 1'b0;
    endcase
  end

  // ================================================================
  // Edge detection; sync path holds an edge until the next instruction tick
  always @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      src_level <= 1'b0;
      edge_prev <= 1'b0;
      sync_hold <= 1'b0;
    end
    else
    begin
      src_level <= next_src_level;
      edge_prev <= src_level;
      // One edge per instruction cycle at most; faster sources merge
      if (instr_tick)
        sync_hold <= raw_rise;
      else if (raw_rise)
        sync_hold <= 1'b1;
    end
  end

  assign raw_rise  = src_level & ~edge_prev;
  assign sync_rise = instr_tick & sync_hold;

  // ================================================================
  // Count tick; sleep halts the instruction and synchronised paths only
  always @*
  begin
    src_tick = 1'b0;
    if (enable)
    begin
      if (src_sel == `ESTC_CS_INSTR)
        src_tick = instr_tick & ~i_sleep;
      else if (unsync)
        src_tick = raw_rise;
      else
        src_tick = sync_rise & ~i_sleep;
    end
  end

  assign presc_clear = i_low_write | i_ctla_write | i_ctlb_write;

  estc_prescaler #(
    .WIDTH (PRESCALE_WIDTH)
  ) u_prescaler (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_clear   (presc_clear),
    .i_tick    (src_tick),
    .i_select  (o_timer_control_b[`ESTC_CTLB_CKPS_MSB:`ESTC_CTLB_CKPS_LSB]),
    .o_tick    (ctr_tick)
  );

  assign match8    = ~wide & (o_count_low_byte == period_buffer);
  assign roll16    = wide & (&o_count_low_byte) & (&true_high);
  assign event_hit = ctr_tick & (match8 | roll16);
  assign post_done = (post_count
                      == o_timer_control_a[`ESTC_CTLA_PS_MSB:`ESTC_CTLA_PS_LSB]);

  // ================================================================
  // Control registers
  always @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_timer_control_a <= `ESTC_CTL_RESET;
      o_timer_control_b <= `ESTC_CTL_RESET;
    end
    else
    begin
      // Bits 6 and 5 of control A are unimplemented and always read as zero
      if (i_ctla_write)
        o_timer_control_a <= {i_wdata[7], 2'h0, i_wdata[4:0]};
      if (i_ctlb_write)
        o_timer_control_b <= i_wdata;
    end
  end

  // ================================================================
  // Count, buffer and period
  always @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_count_low_byte        <= `ESTC_LOW_RESET;
      o_high_buffer_or_period <= `ESTC_HIGH_RESET;
      true_high               <= `ESTC_HIGH_RESET;
      period_buffer           <= `ESTC_HIGH_RESET;
    end
    else if (i_low_write)
    begin
      o_count_low_byte <= i_wdata;
      if (wide)
        true_high <= o_high_buffer_or_period;
    end
    else
    begin
      if (i_high_write)
        o_high_buffer_or_period <= i_wdata;
      else if (i_low_read & wide)
        o_high_buffer_or_period <= true_high;
      if (~wide & i_high_write)
        period_buffer <= i_wdata;
      if (ctr_tick)
      begin
        if (match8)
        begin
          o_count_low_byte <= 8'h00;
          period_buffer    <= o_high_buffer_or_period;
        end
        else
        begin
          o_count_low_byte <= o_count_low_byte + 8'h01;
          if (wide & (&o_count_low_byte))
            true_high <= true_high + 8'h01;
        end
      end
    end
  end

  // ================================================================
  // Postscaler, flag and output
  always @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      post_count           <= 4'h0;
      o_match_event_flag   <= 1'b0;
      o_timer_output_pulse <= 1'b0;
      o_timer_output_level <= 1'b0;
    end
    else
    begin
      if (presc_clear)
        post_count <= 4'h0;
      else if (event_hit)
        post_count <= post_done ? 4'h0 : post_count + 4'h1;
      // Set wins over a simultaneous clear
      if (event_hit & post_done & ~presc_clear)
        o_match_event_flag <= 1'b1;
      else if (i_flag_clear)
        o_match_event_flag <= 1'b0;
      // Pulse held until the next prescaled tick, or until the enable bit clears
      if (event_hit & post_done & ~presc_clear)
      begin
        o_timer_output_pulse <= 1'b1;
        o_timer_output_level <= ~o_timer_output_level;
      end
      else if (ctr_tick | ~enable)
        o_timer_output_pulse <= 1'b0;
    end
  end

endmodule // estc_timer

// File: core/estc_timer_map.vh
// Constants for the 8/16-bit timer/counter: field layouts, reset values, codes.
// Assumes inclusion by bare name from the timer design files.
`ifndef ESTC_TIMER_MAP_VH
`define ESTC_TIMER_MAP_VH

// ==================================================================
// Control field positions
`define ESTC_CTLA_PS_LSB      0
`define ESTC_CTLA_PS_MSB      3
`define ESTC_CTLB_CKPS_LSB    0
`define ESTC_CTLB_CKPS_MSB    3
`define ESTC_CTLB_ASYNC_BIT   4
`define ESTC_CTLB_CS_LSB      5
`define ESTC_CTLB_CS_MSB      7

// ==================================================================
// Reset values
`define ESTC_LOW_RESET        8'h00
`define ESTC_HIGH_RESET       8'hFF
`define ESTC_CTL_RESET        8'h00

// ==================================================================
// Clock source codes
`define ESTC_CS_PIN_TRUE      3'h0
`define ESTC_CS_PIN_INV       3'h1
`define ESTC_CS_INSTR         3'h2
`define ESTC_CS_HFOSC         3'h3
`define ESTC_CS_LFOSC         3'h4
`define ESTC_CS_RSVD          3'h5
`define ESTC_CS_SOSC          3'h6
`define ESTC_CS_LOGIC         3'h7

// ==================================================================
// Timing
`define ESTC_CLK_PERIOD_NS    10
`define ESTC_INSTR_DIV        4
`define ESTC_PRESCALE_WIDTH   15

`endif

// File: testbench/estc_timer_bench.sv
// Self-checking bench for the 8/16-bit timer/counter.
// Assumes the checker is bound in; all clock sources share one slow input.
`timescale 1ns/1ps
module estc_timer_bench;
  localparam LW = 0, HW = 1, LR = 2, CA = 3, CB = 4, FC = 5;
  localparam [71:0] SRC_CB = {8'h10, 8'h30, 8'h70, 8'h90, 8'hB0, 8'hD0, 8'hF0, 8'h00, 8'h00};
  localparam [8:0]  SRC_SL = 9'h00A;
  localparam [8:0]  SRC_NZ = 9'h1ED;
  reg        clk = 1'b0;
  reg        rst = 1'b1;
  reg        sleep = 1'b0;
  reg        src = 1'b0;
  reg  [7:0] wdata = 8'h00;
  reg  [5:0] stb = 6'h00;
  reg  [7:0] prev;
  wire [7:0] low, high, ctla, ctlb;
  wire       pulse, flag, level;
  integer    n_errors = 0;
  integer    n_compared = 0;
  integer    cyc = 0;
  integer    i, g, m;

  estc_timer uut (.i_clk(clk), .i_sys_rst(rst), .i_sleep(sleep), .i_pin_clk(src),
    .i_hfosc_clk(src), .i_lfosc_clk(src), .i_sosc_clk(src), .i_logic_clk(src),
    .i_wdata(wdata), .i_low_write(stb[LW]), .i_high_write(stb[HW]), .i_low_read(stb[LR]),
    .i_ctla_write(stb[CA]), .i_ctlb_write(stb[CB]), .i_flag_clear(stb[FC]),
    .o_count_low_byte(low), .o_high_buffer_or_period(high), .o_timer_control_a(ctla),
    .o_timer_control_b(ctlb), .o_timer_output_pulse(pulse), .o_timer_output_level(level),
    .o_match_event_flag(flag));

  always #5 clk = ~clk;

  // ==================================================================
  // Access tasks
  task conclude;
    begin
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  task check(input [7:0] seen, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp)
      begin
        n_errors = n_errors + 1;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task wr(input integer k, input [7:0] d);
    begin
      @(negedge clk);
      wdata = d;
      stb = 6'h01 << k;
      @(negedge clk);
      stb = 6'h00;
    end
  endtask

  // Control B written while disabled so a source switch cannot count
  task setup(input [7:0] ca, input [7:0] cb, input [7:0] hi, input [7:0] lo);
    begin
      wr(CA, 8'h00);
      wr(CB, cb);
      wr(FC, 8'h00);
      wr(CA, ca);
      wr(HW, hi);
      wr(LW, lo);
    end
  endtask

  task wait_flag;
    begin
      g = 0;
      m = 0;
      prev = low;
      while (flag !== 1'b1 && g < 400)
      begin
        @(negedge clk);
        if (low === 8'h00 && prev !== 8'h00)
          m = m + 1;
        prev = low;
        g = g + 1;
      end
      check({7'h00, flag}, 8'h01);
    end
  endtask

  task wait_change;
    begin
      prev = low;
      g = 0;
      while (low === prev && g < 300)
      begin
        @(negedge clk);
        g = g + 1;
      end
    end
  endtask

  // Half period of two or more cycles keeps sync edges at instruction rate
  task pulse_src(input integer cnt, input integer half);
    begin
      repeat (cnt)
      begin
        src = 1'b1;
        repeat (half) @(negedge clk);
        src = 1'b0;
        repeat (half) @(negedge clk);
      end
    end
  endtask

  // ==================================================================
  // Timeout
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      n_errors = n_errors + 1;
      conclude;
    end
  end

  // ==================================================================
  // Tests
  initial
  begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    check(low, 8'h00);
    check(high, 8'hFF);
    check(ctla, 8'h00);
    wr(CA, 8'hFF);
    check(ctla, 8'h9F);
    wr(CB, 8'hFF);
    check(ctlb, 8'hFF);
    setup(8'h10, 8'h40, 8'h12, 8'h34);
    wr(HW, 8'h55);
    wr(LR, 8'h00);
    check(low, 8'h34);
    check(high, 8'h12);
    setup(8'h10, 8'h40, 8'hFF, 8'hFE);
    wr(CA, 8'h90);
    wait_flag;
    check(low, 8'h00);
    wr(CA, 8'h10);
    wr(LR, 8'h00);
    check(high, 8'h00);
    wr(FC, 8'h00);
    check({7'h00, flag}, 8'h00);
    for (i = 0; i < 3; i = i + 2)
    begin
      setup(8'h00, 8'h40, 8'h03, 8'h00);
      wr(CA, {4'h8, i[3:0]});
      wait_flag;
      check(m[7:0], i[7:0] + 8'h01);
      check({7'h00, pulse}, 8'h01);
      check({7'h00, level}, {7'h00, i[1]});
    end
    for (i = 0; i < 4; i = i + 1)
    begin
      setup(8'h00, {4'h4, i[3:0]}, 8'hFF, 8'h00);
      wr(CA, 8'h80);
      wait_change;
      wait_change;
      check(g[7:0], 8'h04 << i);
    end
    setup(8'h00, 8'h40, 8'hFF, 8'h00);
    repeat (40) @(negedge clk);
    check(low, 8'h00);
    for (i = 0; i < 9; i = i + 1)
    begin
      sleep = SRC_SL[i];
      setup(8'h00, SRC_CB[8*i +: 8], 8'hFF, 8'h00);
      wr(CA, 8'h80);
      pulse_src(5, 8);
      repeat (20) @(negedge clk);
      check(low, SRC_NZ[i] ? 8'h05 : 8'h00);
      sleep = 1'b0;
    end
    setup(8'h00, 8'h00, 8'hFF, 8'h00);
    wr(CA, 8'h80);
    pulse_src(6, 2);
    repeat (8) @(negedge clk);
    check(low, 8'h06);
    setup(8'h00, 8'h12, 8'hFF, 8'h00);
    wr(CA, 8'h80);
    pulse_src(3, 8);
    wr(LW, 8'h00);
    pulse_src(3, 8);
    check(low, 8'h00);
    pulse_src(1, 8);
    check(low, 8'h01);
    setup(8'h00, 8'h10, 8'h00, 8'h00);
    wr(CA, 8'h81);
    pulse_src(1, 8);
    wr(LW, 8'h00);
    pulse_src(1, 8);
    check({7'h00, flag}, 8'h00);
    pulse_src(1, 8);
    check({7'h00, flag}, 8'h01);
    conclude;
  end
endmodule // estc_timer_bench

// File: testbench/estc_timer_chk.sv
// Port-level timing checks for the 8/16-bit timer/counter.
// Assumes it is bound onto estc_timer; one clock, async active-high reset.
`timescale 1ns/1ps
module estc_timer_chk (
  input wire       i_clk,
  input wire       i_sys_rst,
  input wire [7:0] i_wdata,
  input wire       i_low_write,
  input wire       i_high_write,
  input wire       i_low_read,
  input wire       i_ctla_write,
  input wire       i_ctlb_write,
  input wire       i_flag_clear,
  input wire [7:0] o_count_low_byte,
  input wire [7:0] o_high_buffer_or_period,
  input wire [7:0] o_timer_control_a,
  input wire [7:0] o_timer_control_b,
  input wire       o_timer_output_pulse,
  input wire       o_match_event_flag
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  wire en = o_timer_control_a[7];
  wire wide = o_timer_control_a[4];
  // ==================================================================
  // Assertions
  a_reset_values: assert property ($fell(i_sys_rst) |-> o_count_low_byte == 8'h00
    && o_high_buffer_or_period == 8'hFF) else $error("reset values wrong");
  a_low_load: assert property (i_low_write |=> o_count_low_byte == $past(i_wdata))
    else $error("low count not loaded");
  a_high_load: assert property (i_high_write && !i_low_write && !i_low_read
    |=> o_high_buffer_or_period == $past(i_wdata)) else $error("high not loaded");
  a_ctla_readback: assert property (i_ctla_write
    |=> o_timer_control_a == ($past(i_wdata) & 8'h9F)) else $error("control a wrong");
  a_ctlb_readback: assert property (i_ctlb_write
    |=> o_timer_control_b == $past(i_wdata)) else $error("control b wrong");
  a_disabled_hold: assert property (!en && !$past(en) && !i_low_write
    |=> $stable(o_count_low_byte) && !$rose(o_match_event_flag)) else $error("moved while off");
  a_flag_clears: assert property (i_flag_clear && !en && !$past(en)
    |=> !o_match_event_flag) else $error("flag not cleared");
  a_pulse_flag: assert property ($rose(o_timer_output_pulse) |-> o_match_event_flag)
    else $error("pulse without flag");
  a_match_low: assert property ($rose(o_timer_output_pulse) && !wide
    |-> o_count_low_byte == 8'h00) else $error("match did not clear low");
  c_flag: cover property ($rose(o_match_event_flag));
  c_wide_read: cover property (i_low_read && wide);
  c_pulse8: cover property ($rose(o_timer_output_pulse) && !wide);
endmodule // estc_timer_chk

bind estc_timer estc_timer_chk u_chk (.i_clk, .i_sys_rst, .i_wdata, .i_low_write,
  .i_high_write, .i_low_read, .i_ctla_write, .i_ctlb_write, .i_flag_clear,
  .o_count_low_byte, .o_high_buffer_or_period, .o_timer_control_a,
  .o_timer_control_b, .o_timer_output_pulse, .o_match_event_flag);
